// ===== design/lfo_regs.svh
// register offsets, field positions, reset values and timing counts of the low-frequency osc block
`ifndef LFO_REGS_SVH
`define LFO_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LFO_OSC_CTRL_ADDR   8'h86
`define LFO_MULT_CTRL_ADDR  8'hB9

// ----------------------------------------------------------------
// low_freq_osc_control fields
// ----------------------------------------------------------------
`define LFO_EN_BIT          7
`define LFO_RDY_BIT         6
`define LFO_TRIM_MSB        5
`define LFO_TRIM_LSB        2
`define LFO_DIV_MSB         1
`define LFO_DIV_LSB         0
`define LFO_EN_RST          1'h0
`define LFO_DIV_RST         2'h0
`define LFO_TRIM_RST        4'h8

// ----------------------------------------------------------------
// multiplier_compat_control fields
// ----------------------------------------------------------------
`define LFO_MULT_EN_BIT     7
`define LFO_MULT_INIT_BIT   6
`define LFO_MULT_LOCK_BIT   5
`define LFO_MULT_SEL_MSB    1
`define LFO_MULT_SEL_LSB    0
`define LFO_MULT_RD         8'hE0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LFO_SETTLE_EDGES    5'h10

`endif

// ===== design/lfo_pkg.sv
// types of the low-frequency osc block
package lfo_pkg;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LFO_DIV8 = 2'h0,
    LFO_DIV4 = 2'h1,
    LFO_DIV2 = 2'h2,
    LFO_DIV1 = 2'h3
  } lfo_div_sel_t;

  typedef enum logic [1:0] {
    LFO_MSEL_HFOSC  = 2'h0,
    LFO_MSEL_EXT    = 2'h1,
    LFO_MSEL_EXT_D2 = 2'h2,
    LFO_MSEL_RSVD   = 2'h3
  } lfo_mult_sel_t;

  // ----------------------------------------------------------------
  // ready tracking states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LFO_RDY_OFF,
    LFO_RDY_SETTLE,
    LFO_RDY_ON
  } lfo_rdy_state_t;

endpackage : lfo_pkg

// ===== design/lfo_divider.sv
// output divider of the low-frequency oscillator
`include "lfo_regs.svh"

module lfo_divider
  import lfo_pkg::*;
#(
  parameter int CNT_W = 3
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // control
  input  wire logic         enable,
  input  wire logic         restart,
  input  wire lfo_div_sel_t div_sel,
  // source edges and output
  input  wire logic         raw_edge,
  output logic              div_out
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             out_q;
  logic             out_d;
  logic [CNT_W-1:0] last_cnt;

  // edges per output half period, minus one
  always_comb begin
    unique case (div_sel)
      LFO_DIV8: last_cnt = CNT_W'(7);
      LFO_DIV4: last_cnt = CNT_W'(3);
      LFO_DIV2: last_cnt = CNT_W'(1);
      LFO_DIV1: last_cnt = CNT_W'(0);
    endcase
  end

  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!enable) begin
      cnt_d = '0;
      out_d = 1'b0;
    end else if (restart) begin
      cnt_d = '0;
    end else if (raw_edge) begin
      if (cnt_q >= last_cnt) begin
        cnt_d = '0;
        out_d = ~out_q;
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign div_out = out_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  div_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    !enable |=> !div_out)
    else $error("divided output active while oscillator disabled");

  div_by_one_a: assert property (@(posedge clk_sys) disable iff (rst)
    enable && !restart && raw_edge && div_sel == LFO_DIV1 |=> div_out != $past(div_out))
    else $error("divide by one did not follow source edge");

endmodule : lfo_divider

// ===== design/lfo_ctrl.sv
// low-frequency osc control, multiplier compatibility register and timer capture path
//
// Operation
// - The multiplier enable, initialize and locked bits always read 1, whatever is written.
// - The multiplier input select field always reads 00.
// - The oscillator output is divided by 8, 4, 2 or 1 per the divider field, reset 00.
// - Bit 7 enables the oscillator when 1 and disables it when 0, reset 0.
// - The ready flag reads 1 once stable and falls on reset, on disable or on a divider change.
// - The 4-bit trim in bits 5 to 2 tunes the frequency, 0000b fastest, 1111b slowest.
// - In capture mode timer two captures on falling and timer three on rising output edges.
// - Each capture copies the timer's 16-bit count into its reload pair.
`include "lfo_regs.svh"

module lfo_ctrl
  import lfo_pkg::*;
#(
  parameter logic [3:0] TRIM_RESET = `LFO_TRIM_RST,
  parameter int         TMR_W      = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // register port
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [7:0]       rdata,
  // oscillator
  input  wire logic             lf_osc_raw,
  output logic                  lf_osc_enable,
  output logic      [3:0]       lf_trim,
  output logic                  lf_div_out,
  // timers
  input  wire logic             t2_cap_mode,
  input  wire logic             t3_cap_mode,
  input  wire logic [TMR_W-1:0] t2_count,
  input  wire logic [TMR_W-1:0] t3_count,
  output logic      [TMR_W-1:0] t2_reload,
  output logic      [TMR_W-1:0] t3_reload,
  output logic                  t2_cap_pulse,
  output logic                  t3_cap_pulse
);

  // ----------------------------------------------------------------
  // source synchroniser
  // ----------------------------------------------------------------
  logic raw_s1_q;
  logic raw_s2_q;
  logic raw_s3_q;
  logic raw_edge;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      raw_s1_q <= 1'b0;
      raw_s2_q <= 1'b0;
      raw_s3_q <= 1'b0;
    end else begin
      raw_s1_q <= lf_osc_raw;
      raw_s2_q <= raw_s1_q;
      raw_s3_q <= raw_s2_q;
    end
  end

  assign raw_edge = raw_s2_q ^ raw_s3_q;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic         en_q;
  logic         en_d;
  logic [3:0]   trim_q;
  logic [3:0]   trim_d;
  lfo_div_sel_t div_q;
  lfo_div_sel_t div_d;
  logic         osc_wr;
  logic         div_change;

  assign osc_wr     = wr && (addr == `LFO_OSC_CTRL_ADDR);
  assign div_change = osc_wr && (wdata[`LFO_DIV_MSB:`LFO_DIV_LSB] != div_q);

  always_comb begin
    en_d   = en_q;
    trim_d = trim_q;
    div_d  = div_q;
    if (osc_wr) begin
      en_d   = wdata[`LFO_EN_BIT];
      trim_d = wdata[`LFO_TRIM_MSB:`LFO_TRIM_LSB];
      div_d  = lfo_div_sel_t'(wdata[`LFO_DIV_MSB:`LFO_DIV_LSB]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_q   <= `LFO_EN_RST;
      trim_q <= TRIM_RESET;
      div_q  <= lfo_div_sel_t'(`LFO_DIV_RST);
    end else begin
      en_q   <= en_d;
      trim_q <= trim_d;
      div_q  <= div_d;
    end
  end

  assign lf_osc_enable = en_q;
  assign lf_trim       = trim_q;

  // ----------------------------------------------------------------
  // ready tracking
  // ----------------------------------------------------------------
  lfo_rdy_state_t rdy_q;
  lfo_rdy_state_t rdy_d;
  logic [4:0]     settle_q;
  logic [4:0]     settle_d;
  logic           ready;

  always_comb begin
    rdy_d    = rdy_q;
    settle_d = settle_q;
    unique case (rdy_q)
      LFO_RDY_OFF: begin
        settle_d = '0;
        if (en_q) begin
          rdy_d = LFO_RDY_SETTLE;
        end
      end
      LFO_RDY_SETTLE: begin
        if (raw_edge) begin
          settle_d = settle_q + 5'h01;
        end
        if (settle_q == `LFO_SETTLE_EDGES) begin
          rdy_d = LFO_RDY_ON;
        end
      end
      LFO_RDY_ON: begin
        settle_d = '0;
      end
    endcase
    if (!en_q) begin
      rdy_d    = LFO_RDY_OFF;
      settle_d = '0;
    end else if (div_change) begin
      rdy_d    = LFO_RDY_SETTLE;
      settle_d = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdy_q    <= LFO_RDY_OFF;
      settle_q <= '0;
    end else begin
      rdy_q    <= rdy_d;
      settle_q <= settle_d;
    end
  end

  assign ready = (rdy_q == LFO_RDY_ON);

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  lfo_divider #(
    .CNT_W    (3)
  ) u_div (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .enable   (en_q),
    .restart  (div_change),
    .div_sel  (div_q),
    .raw_edge (raw_edge),
    .div_out  (lf_div_out)
  );

  // ----------------------------------------------------------------
  // timer capture
  // ----------------------------------------------------------------
  logic             div_prev_q;
  logic             fall_edge;
  logic             rise_edge;
  logic [TMR_W-1:0] t2_rl_q;
  logic [TMR_W-1:0] t2_rl_d;
  logic [TMR_W-1:0] t3_rl_q;
  logic [TMR_W-1:0] t3_rl_d;
  logic             t2_cap_q;
  logic             t2_cap_d;
  logic             t3_cap_q;
  logic             t3_cap_d;

  assign fall_edge = div_prev_q && !lf_div_out;
  assign rise_edge = !div_prev_q && lf_div_out;

  always_comb begin
    t2_rl_d  = t2_rl_q;
    t3_rl_d  = t3_rl_q;
    t2_cap_d = t2_cap_mode && fall_edge;
    t3_cap_d = t3_cap_mode && rise_edge;
    if (t2_cap_d) begin
      t2_rl_d = t2_count;
    end
    if (t3_cap_d) begin
      t3_rl_d = t3_count;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_prev_q <= 1'b0;
      t2_rl_q    <= '0;
      t3_rl_q    <= '0;
      t2_cap_q   <= 1'b0;
      t3_cap_q   <= 1'b0;
    end else begin
      div_prev_q <= lf_div_out;
      t2_rl_q    <= t2_rl_d;
      t3_rl_q    <= t3_rl_d;
      t2_cap_q   <= t2_cap_d;
      t3_cap_q   <= t3_cap_d;
    end
  end

  assign t2_reload    = t2_rl_q;
  assign t3_reload    = t3_rl_q;
  assign t2_cap_pulse = t2_cap_q;
  assign t3_cap_pulse = t3_cap_q;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (rd) begin
      if (addr == `LFO_OSC_CTRL_ADDR) begin
        rdata_d = {en_q, ready, trim_q, div_q};
      end else if (addr == `LFO_MULT_CTRL_ADDR) begin
        rdata_d = `LFO_MULT_RD;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  mult_fixed_ones_a: assert property (
    rd && addr == `LFO_MULT_CTRL_ADDR |=> rdata[7:5] == 3'h7)
    else $error("multiplier status bits not read as ones");

  mult_sel_zero_a: assert property (
    rd && addr == `LFO_MULT_CTRL_ADDR |=> rdata[1:0] == 2'h0)
    else $error("multiplier select not read as zero");

  mult_unused_zero_a: assert property (
    wr && addr == `LFO_MULT_CTRL_ADDR ##[1:2] rd && addr == `LFO_MULT_CTRL_ADDR
    |=> rdata[4:2] == 3'h0)
    else $error("multiplier unused bits not zero");

  div_reset_a: assert property (
    $past(rst) |-> div_q == LFO_DIV8)
    else $error("divider select not reset to divide by 8");

  enable_write_a: assert property (
    osc_wr |=> lf_osc_enable == $past(wdata[7]))
    else $error("enable bit not taken from write");

  trim_write_a: assert property (
    osc_wr ##1 !wr ##1 rd && addr == `LFO_OSC_CTRL_ADDR |=> rdata[5:2] == $past(wdata[5:2], 3))
    else $error("trim field read back wrong");

  ready_hold_a: assert property (
    ready && en_q && !div_change |=> ready)
    else $error("ready flag fell without divider change");

  ready_off_a: assert property (
    !en_q |=> !ready)
    else $error("ready flag set while disabled");

  cap_fall_a: assert property (
    t2_cap_mode && fall_edge |=> t2_cap_pulse && t2_reload == $past(t2_count))
    else $error("timer two capture missed");

  cap_rise_a: assert property (
    t3_cap_mode && rise_edge |=> t3_cap_pulse && t3_reload == $past(t3_count))
    else $error("timer three capture missed");

  ready_seen_c:   cover property ($rose(ready));
  t2_capture_c:   cover property (t2_cap_pulse ##[1:200] t2_cap_pulse);
  t3_capture_c:   cover property (t3_cap_pulse);
  div_restart_c:  cover property (ready && div_change);

endmodule : lfo_ctrl

// ===== dv/lfo_ctrl_tb_top.sv
// self-checking testbench of the low-frequency osc control block
module lfo_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lfo_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_sys;
  logic        rst;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        lf_osc_raw;
  logic        lf_osc_enable;
  logic [3:0]  lf_trim;
  logic        lf_div_out;
  logic        t2_cap_mode;
  logic        t3_cap_mode;
  logic [15:0] t2_count;
  logic [15:0] t3_count;
  logic [15:0] t2_reload;
  logic [15:0] t3_reload;
  logic        t2_cap_pulse;
  logic        t3_cap_pulse;
  int          num_errors;
  int          n_compared;
  logic        raw_run;
  int          ph;
  logic        raw_prev;
  logic        div_prev;
  int          rise_cnt;
  int          gap;
  int          div_rises;
  int          p2;
  int          p3;
  logic [15:0] c2_prev;
  logic [15:0] c3_prev;
  logic [7:0]  rv;
  int          s_rises;
  int          s2;
  int          s3;
  logic [23:0] mseq;
  logic [15:0] c2_cal;

  lfo_ctrl u_dut (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .addr         (addr),
    .wdata        (wdata),
    .wr           (wr),
    .rd           (rd),
    .rdata        (rdata),
    .lf_osc_raw   (lf_osc_raw),
    .lf_osc_enable(lf_osc_enable),
    .lf_trim      (lf_trim),
    .lf_div_out   (lf_div_out),
    .t2_cap_mode  (t2_cap_mode),
    .t3_cap_mode  (t3_cap_mode),
    .t2_count     (t2_count),
    .t3_count     (t3_count),
    .t2_reload    (t2_reload),
    .t3_reload    (t3_reload),
    .t2_cap_pulse (t2_cap_pulse),
    .t3_cap_pulse (t3_cap_pulse)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic wait_ready;
    rv = 8'h00;
    for (int i = 0; i < 200 && rv[6] !== 1'b1; i++) begin
      reg_rd(8'h86, rv);
    end
  endtask : wait_ready

  task automatic test_done;
    $display("TB: errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // clock, raw oscillator, timers and monitors
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    t2_count <= t2_count + 16'h0001;
    t3_count <= t3_count + 16'h0003;
    if (raw_run) begin
      ph <= (ph == 3) ? 0 : ph + 1;
      if (ph == 3) begin
        lf_osc_raw <= ~lf_osc_raw;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (lf_osc_raw === 1'b1 && raw_prev === 1'b0) rise_cnt++;
    if (lf_div_out === 1'b1 && div_prev === 1'b0) begin
      gap = rise_cnt;
      rise_cnt = 0;
      div_rises++;
    end
    if (t2_cap_pulse === 1'b1) begin
      p2++;
      check(t2_reload, c2_prev, "t2 reload");
      check(lf_div_out, 1'b0, "t2 edge");
    end
    if (t3_cap_pulse === 1'b1) begin
      p3++;
      check(t3_reload, c3_prev, "t3 reload");
      check(lf_div_out, 1'b1, "t3 edge");
    end
    raw_prev = lf_osc_raw;
    div_prev = lf_div_out;
    c2_prev  = t2_count;
    c3_prev  = t3_count;
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    lf_osc_raw = 1'b0; t2_cap_mode = 1'b0; t3_cap_mode = 1'b0;
    t2_count = 16'h1234; t3_count = 16'hA000; raw_run = 1'b0; ph = 0;
    num_errors = 0; n_compared = 0; rise_cnt = 0; gap = 0; div_rises = 0; p2 = 0; p3 = 0;
    mseq = 24'hFF001C;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    reg_rd(8'h86, rv);
    check(rv, 8'h20, "osc ctrl reset");
    check(lf_osc_enable, 1'b0, "enable reset");
    check(lf_trim, 4'h8, "trim reset");
    for (int i = 0; i < 3; i++) begin
      reg_wr(8'hB9, mseq[23 - 8 * i -: 8]);
      reg_rd(8'hB9, rv);
      check(rv, 8'hE0, "mult reg");
    end
    reg_wr(8'hB9, 8'h80);
    reg_wr(8'hB9, 8'hC0);
    reg_rd(8'hB9, rv);
    check(rv[5], 1'b1, "locked after init");
    reg_wr(8'h00, 8'hFF);
    reg_rd(8'h00, rv);
    check(rv, 8'h00, "unmapped read");
    reg_wr(8'h86, 8'h40);
    reg_rd(8'h86, rv);
    check(rv, 8'h00, "ready write ignored");
    check(lf_trim, 4'h0, "trim fastest");
    raw_run <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      reg_wr(8'h86, 8'hBC | 8'(d));
      reg_rd(8'h86, rv);
      check(rv[6], 1'b0, "ready after change");
      wait_ready();
      check(rv, 8'hFC | 8'(d), "ready set");
      check(lf_osc_enable, 1'b1, "enable on");
      check(lf_trim, 4'hF, "trim slowest");
      s_rises = div_rises;
      for (int i = 0; i < 400 && div_rises < s_rises + 3; i++) @(posedge clk_sys);
      check(16'(gap), 16'(8 >> d), "divider period");
    end
    reg_wr(8'h86, 8'h83);
    reg_rd(8'h86, rv);
    check(rv, 8'hC3, "same div keeps ready");
    t2_cap_mode <= 1'b1;
    s2 = p2; s3 = p3;
    repeat (80) @(posedge clk_sys);
    check(16'(p2 - s2 > 7), 16'h0001, "t2 captures");
    check(16'(p3 - s3), 16'h0000, "t3 idle");
    @(posedge clk_sys iff t2_cap_pulse === 1'b1);
    c2_cal = t2_reload;
    @(posedge clk_sys iff t2_cap_pulse === 1'b1);
    check(t2_reload - c2_cal, 16'h0008, "capture period");
    t2_cap_mode <= 1'b0;
    t3_cap_mode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    s2 = p2; s3 = p3;
    repeat (80) @(posedge clk_sys);
    check(16'(p3 - s3 > 7), 16'h0001, "t3 captures");
    check(16'(p2 - s2), 16'h0000, "t2 idle");
    t2_cap_mode <= 1'b1;
    reg_wr(8'h86, 8'h03);
    repeat (8) @(posedge clk_sys);
    s_rises = div_rises; s2 = p2; s3 = p3;
    repeat (100) @(posedge clk_sys);
    check(16'(div_rises - s_rises), 16'h0000, "quiet output");
    check(16'(p2 + p3 - s2 - s3), 16'h0000, "no captures");
    check(lf_div_out, 1'b0, "output low");
    reg_rd(8'h86, rv);
    check(rv, 8'h03, "ready off when disabled");
    reg_wr(8'h86, 8'h81);
    wait_ready();
    check(rv[6], 1'b1, "ready again");
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    reg_rd(8'h86, rv);
    check(rv, 8'h20, "reset clears ready");
    test_done();
  end

endmodule : lfo_ctrl_tb_top
